// ---- src/krs_defs.svh ----
`ifndef KRS_DEFS_SVH
`define KRS_DEFS_SVH
// Register byte offsets
`define KRS_OFF_CTRL     8'h00
`define KRS_OFF_GUARD    8'h04
`define KRS_OFF_COEF     8'h08
`define KRS_OFF_SCOPE    8'h0c
`define KRS_OFF_STATUS   8'h10
`define KRS_OFF_KEYSEL   8'h14
`define KRS_OFF_KEYERR   8'h18
`define KRS_OFF_ERRLO    8'h1c
`define KRS_OFF_ERRHI    8'h20
`define KRS_OFF_SUPLO    8'h24
`define KRS_OFF_SUPHI    8'h28
// Control bits and scope all-keys bit
`define KRS_CTRL_LOCK    0
`define KRS_CTRL_RECAL   1
`define KRS_CTRL_SOFTRST 2
`define KRS_SCOPE_ALL    8
// Status bits
`define KRS_ST_DETECT    0
`define KRS_ST_CAL       1
`define KRS_ST_ERROR     2
`define KRS_ST_SETUP     4
// Guardband ranges and window boundaries
`define KRS_NEG_MAX      7'd99
`define KRS_POS_MAX      7'd100
`define KRS_POS_STEP     11'd10
`define KRS_PCT_FULL     11'd100
`define KRS_BOUND_HI     8'd191
`define KRS_BOUND_LO     8'd64
// Burst cycles for one full recalibration
`define KRS_FULL_CAL_BURSTS 5'd26
// Reset values
`define KRS_RST_COARSE   16'h0000
`define KRS_RST_FINE     8'h00
`endif

// ---- src/krs_pkg.sv ----
package krs_pkg;
	typedef struct packed {
		logic       valid;
		logic [5:0] key;
		logic [7:0] reference;
		logic [7:0] signal;
		logic [3:0] cancel_cap_count;
		logic [7:0] ladder_offset;
		logic       detect;
	} krs_update_type;
	typedef struct packed {
		logic       valid;
		logic [5:0] key;
		logic [7:0] value;
	} krs_fast_set_type;
endpackage

// ---- src/krs_supervisor.sv ----
`timescale 1ns/1ps
`include "krs_defs.svh"
// What this block does
// RL1: Negative guardband accepts 1..99 percent, one global value for all keys.
// RL2: Positive guardband accepts 10..1000 percent in tens, global for all keys.
// RL3: Zero guardband disables only that direction of checking.
// RL4: Absolute reference is coarse times cancel count plus fine times offset plus window.
// RL5: Lock stores each absolute reference; later running values compare to it.
// RL6: Guard checks run only after recalibration or soft reset following lock.
// RL7: New coarse and fine offsets affect a key only after its full recalibration.
// RL8: Guard violation sets key error bit 2 or 3 and the all-keys bitfield.
// RL9: Guard crossing never starts automatic recalibration.
// RL10: Host loads coarse 1513 as 0x05/0xe9 and fine 8.
// RL11: Enabled key suppressed when another enabled key deviates more negatively.
// RL12: Suppression compares raw deviations, no gain or threshold weighting.
// RL13: Power-up, resets and recalibrate command start full recalibration.
// RL14: Full recalibration takes 26 burst cycles, fast takes one.
// RL15: Recalibrate acts on the whole scope at once, in parallel.
// RL16: Error bit 2 when window reference above 191, bit 3 below 64.
// RL17: Boundary checks use the current window only, no recalibration needed.
// RL18: Boundary errors also appear in the all-keys bitfield.
// RL19: Host recalibrates a key showing a boundary error.
// RL20: Status byte summarises detecting, calibrating and error.
// RL21: Status bit 4 on store mismatch or uncopied setup change.
// RL22: At reset copy store to backup if valid, else restore from backup.
// RL23: Fast recalibration sets reference to signal, offsets untouched.
// RL24: Guard limits are stored value minus and plus percentages, never wrapping.
module krs_supervisor
	import krs_pkg::*;
#(
	parameter int NUM_KEYS = 64
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic [31:0]            hrdata,
	input  wire krs_update_type    upd,
	input  wire logic              burst_tick,
	input  wire logic              fast_req,
	input  wire logic [5:0]        fast_key,
	output krs_fast_set_type       fast_set,
	output logic [NUM_KEYS-1:0]    cal_keys,
	output logic [NUM_KEYS-1:0]    detect_keys,
	input  wire logic              store_valid,
	input  wire logic              store_mismatch,
	output logic                   backup_copy,
	output logic                   backup_restore
);
	if (NUM_KEYS < 2 || NUM_KEYS > 64) begin : g_bad_keys
		$error("NUM_KEYS must be 2..64");
	end

	function automatic logic [63:0] key_bit(input logic [5:0] k);
		key_bit = 64'h1 << k;
	endfunction

	function automatic logic [23:0] abs_ref(input logic [15:0] coarse, input logic [7:0] fine,
			input logic [3:0] cnt, input logic [7:0] ofs, input logic [7:0] wref);
		abs_ref = 24'(coarse) * 24'(cnt) + 24'(fine) * 24'(ofs) + 24'(wref); // RL4
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, read data registered in the address phase
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic [31:0] rdata_q;
	wire         acc = hsel & htrans[1] & hready;
	wire         do_wr = wr_pend_q;
	wire [31:0]  wd = hwdata;

	logic [6:0]  neg_pct_q;
	logic [6:0]  pos_step_q;
	logic [15:0] coarse_q;
	logic [7:0]  fine_q;
	logic [8:0]  scope_q;
	logic [5:0]  keysel_q;
	logic [63:0] supp_en_q;
	logic        setup_dirty_q;
	logic        setup_chk_q;

	wire wr_ctrl  = do_wr && wr_addr_q == `KRS_OFF_CTRL;
	wire wr_guard = do_wr && wr_addr_q == `KRS_OFF_GUARD;
	wire wr_coef  = do_wr && wr_addr_q == `KRS_OFF_COEF;
	wire wr_suplo = do_wr && wr_addr_q == `KRS_OFF_SUPLO;
	wire wr_suphi = do_wr && wr_addr_q == `KRS_OFF_SUPHI;
	wire soft_rst = wr_ctrl && wd[`KRS_CTRL_SOFTRST];
	wire lock_cmd = wr_ctrl && wd[`KRS_CTRL_LOCK];
	wire cal_cmd  = (wr_ctrl && wd[`KRS_CTRL_RECAL]) || soft_rst; // RL13
	// Out-of-range settings are dropped so the old value stays in force
	wire neg_ok = wd[6:0] <= `KRS_NEG_MAX; // RL1
	wire pos_ok = wd[14:8] <= `KRS_POS_MAX; // RL2

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else begin
			wr_pend_q <= acc & hwrite;
			wr_addr_q <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			neg_pct_q  <= 7'h00;
			pos_step_q <= 7'h00;
			coarse_q   <= `KRS_RST_COARSE;
			fine_q     <= `KRS_RST_FINE;
			scope_q    <= 9'h100;
			keysel_q   <= 6'h00;
			supp_en_q  <= 64'h0;
		end else begin
			if (wr_guard && neg_ok)
				neg_pct_q <= wd[6:0]; // RL1
			if (wr_guard && pos_ok)
				pos_step_q <= wd[14:8]; // RL2
			if (wr_coef) begin
				coarse_q <= wd[15:0];
				fine_q   <= wd[23:16];
			end
			if (do_wr && wr_addr_q == `KRS_OFF_SCOPE)
				scope_q <= wd[8:0];
			if (do_wr && wr_addr_q == `KRS_OFF_KEYSEL)
				keysel_q <= wd[5:0];
			if (wr_suplo)
				supp_en_q[31:0] <= wd;
			if (wr_suphi)
				supp_en_q[63:32] <= wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Setup store supervision
	wire setup_wr = wr_guard | wr_coef | wr_suplo | wr_suphi;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			setup_chk_q    <= 1'b1;
			setup_dirty_q  <= 1'b0;
			backup_copy    <= 1'b0;
			backup_restore <= 1'b0;
		end else begin
			setup_chk_q    <= soft_rst;
			backup_copy    <= setup_chk_q & store_valid; // RL22
			backup_restore <= setup_chk_q & ~store_valid; // RL22
			// A change in the same cycle as the copy stays pending
			if (setup_wr)
				setup_dirty_q <= 1'b1; // RL21
			else if (setup_chk_q)
				setup_dirty_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Full and fast recalibration
	logic        cal_busy_q;
	logic [4:0]  cal_cnt_q;
	logic [63:0] cal_mask_q;
	logic [63:0] cal_latch_q;
	logic [63:0] armed_q;
	logic        lock_done_q;
	wire [63:0]  key_valid = (NUM_KEYS == 64) ? {64{1'b1}} : ~({64{1'b1}} << NUM_KEYS);
	wire [63:0]  scope_mask = scope_q[`KRS_SCOPE_ALL] ? key_valid : key_bit(scope_q[5:0]);
	wire [63:0]  cal_scope = soft_rst ? key_valid : scope_mask; // RL13
	wire         cal_end = cal_busy_q && burst_tick && cal_cnt_q == `KRS_FULL_CAL_BURSTS - 5'd1;
	wire         upd_ok = upd.valid && upd.key < NUM_KEYS;
	wire [63:0]  upd_bit = upd_ok ? key_bit(upd.key) : 64'h0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_busy_q <= 1'b1; // RL13
			cal_cnt_q  <= 5'h00;
			cal_mask_q <= {64{1'b1}};
		end else if (cal_cmd) begin
			cal_busy_q <= 1'b1; // RL15
			cal_cnt_q  <= 5'h00;
			cal_mask_q <= (cal_busy_q ? cal_mask_q : 64'h0) | cal_scope; // RL15
		end else if (cal_end) begin
			cal_busy_q <= 1'b0; // RL14
			cal_cnt_q  <= 5'h00;
			cal_mask_q <= 64'h0;
		end else if (cal_busy_q && burst_tick) begin
			cal_cnt_q <= cal_cnt_q + 5'd1; // RL14
		end
	end
	assign cal_keys = cal_mask_q[NUM_KEYS-1:0];

	// Keys finishing full cal take new offsets on their next update
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_latch_q <= 64'h0;
			armed_q     <= 64'h0;
		end else begin
			cal_latch_q <= (cal_latch_q & ~upd_bit) | (cal_end ? cal_mask_q : 64'h0); // RL7
			if (lock_cmd)
				armed_q <= 64'h0; // RL6
			else
				armed_q <= armed_q | ((cal_end && lock_done_q) ? cal_mask_q : 64'h0); // RL6
		end
	end

	logic [7:0] sig_q [NUM_KEYS];
	logic [7:0] ref_q [NUM_KEYS];
	logic [3:0] ev_cnt_q [NUM_KEYS];
	logic [7:0] ev_ofs_q [NUM_KEYS];
	wire  [5:0] fk = fast_key;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			fast_set <= '0;
		else begin
			fast_set.valid <= fast_req && fk < NUM_KEYS; // RL14
			fast_set.key   <= fk;
			fast_set.value <= sig_q[fk[$clog2(NUM_KEYS)-1:0]]; // RL23
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-key tracking, boundary and guard evaluation
	wire [5:0]  uk = upd.key;
	wire [$clog2(NUM_KEYS)-1:0] ui = uk[$clog2(NUM_KEYS)-1:0];
	wire        use_new = cal_latch_q[uk];
	wire [3:0]  e_cnt = use_new ? upd.cancel_cap_count : ev_cnt_q[ui]; // RL7
	wire [7:0]  e_ofs = use_new ? upd.ladder_offset : ev_ofs_q[ui]; // RL7
	wire [23:0] run_abs = abs_ref(coarse_q, fine_q, e_cnt, e_ofs, upd.reference); // RL5
	logic [23:0] locked_q [NUM_KEYS];
	wire [39:0] run_x100 = 40'(run_abs) * 40'(`KRS_PCT_FULL);
	// Wide products stand in for saturating limits: nothing can wrap
	wire [39:0] lim_lo = 40'(locked_q[ui]) * 40'(`KRS_PCT_FULL - 11'(neg_pct_q)); // RL24
	wire [39:0] lim_hi = 40'(locked_q[ui])
		* 40'(`KRS_PCT_FULL + 11'(pos_step_q) * `KRS_POS_STEP); // RL24
	wire g_lo = armed_q[uk] && neg_pct_q != 7'h00 && run_x100 < lim_lo; // RL3
	wire g_hi = armed_q[uk] && pos_step_q != 7'h00 && run_x100 > lim_hi; // RL3
	wire b_hi = upd.reference > `KRS_BOUND_HI; // RL16 RL17
	wire b_lo = upd.reference < `KRS_BOUND_LO; // RL16 RL17

	logic [63:0] err_hi_q;
	logic [63:0] err_lo_q;
	logic [63:0] raw_det_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			err_hi_q  <= 64'h0;
			err_lo_q  <= 64'h0;
			raw_det_q <= 64'h0;
		end else if (upd_ok) begin
			err_hi_q[uk]  <= b_hi | g_hi; // RL8
			err_lo_q[uk]  <= b_lo | g_lo; // RL8
			raw_det_q[uk] <= upd.detect;
		end
	end

	always_ff @(posedge hclk) begin
		if (upd_ok) begin
			sig_q[ui] <= upd.signal;
			ref_q[ui] <= upd.reference;
			ev_cnt_q[ui] <= e_cnt;
			ev_ofs_q[ui] <= e_ofs;
		end
	end

	// Lock walks the keys one per cycle
	logic       lock_busy_q;
	logic [5:0] lock_idx_q;
	wire  [$clog2(NUM_KEYS)-1:0] li = lock_idx_q[$clog2(NUM_KEYS)-1:0];
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lock_busy_q <= 1'b0;
			lock_idx_q  <= 6'h00;
			lock_done_q <= 1'b0;
		end else if (lock_cmd) begin
			lock_busy_q <= 1'b1;
			lock_idx_q  <= 6'h00;
			lock_done_q <= 1'b0;
		end else if (lock_busy_q) begin
			lock_idx_q <= lock_idx_q + 6'd1;
			if (lock_idx_q == 6'(NUM_KEYS - 1)) begin
				lock_busy_q <= 1'b0;
				lock_done_q <= 1'b1; // RL5
			end
		end
	end
	always_ff @(posedge hclk) begin
		if (lock_busy_q)
			locked_q[li] <= abs_ref(coarse_q, fine_q, ev_cnt_q[li], ev_ofs_q[li], ref_q[li]); // RL5
	end

	////////////////////////////////////////////////////////////////////////////////
	// Neighbour suppression on raw deviations
	logic signed [8:0] dev [NUM_KEYS];
	logic [63:0]       beaten;
	genvar gk, gj;
	generate
		for (gk = 0; gk < 64; gk++) begin : g_beat
			if (gk < NUM_KEYS) begin : g_on
				logic [NUM_KEYS-1:0] more;
				assign dev[gk] = $signed({1'b0, sig_q[gk]}) - $signed({1'b0, ref_q[gk]}); // RL12
				for (gj = 0; gj < NUM_KEYS; gj++) begin : g_cmp
					assign more[gj] = (gj != gk) && supp_en_q[gj] && dev[gj] < dev[gk]; // RL11
				end
				assign beaten[gk] = supp_en_q[gk] && |more; // RL11
			end else begin : g_off
				assign beaten[gk] = 1'b0;
			end
		end
	endgenerate
	logic [63:0] det_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			det_q <= 64'h0;
		else
			det_q <= raw_det_q & ~beaten & key_valid; // RL11
	end
	assign detect_keys = det_q[NUM_KEYS-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Read mux
	wire [63:0] err_map = (err_hi_q | err_lo_q) & key_valid; // RL8 RL18
	wire [7:0]  status = {3'b000, setup_dirty_q | store_mismatch, 1'b0, |err_map,
		cal_busy_q | lock_busy_q, |det_q}; // RL20 RL21
	logic [31:0] rmux;
	always_comb begin
		case (haddr[7:0])
			`KRS_OFF_GUARD:  rmux = {17'h0, pos_step_q, 1'b0, neg_pct_q};
			`KRS_OFF_COEF:   rmux = {8'h00, fine_q, coarse_q};
			`KRS_OFF_SCOPE:  rmux = {23'h0, scope_q};
			`KRS_OFF_STATUS: rmux = {24'h0, status}; // RL20
			`KRS_OFF_KEYSEL: rmux = {26'h0, keysel_q};
			`KRS_OFF_KEYERR: rmux = {28'h0, err_lo_q[keysel_q], err_hi_q[keysel_q], 2'b00}; // RL8
			`KRS_OFF_ERRLO:  rmux = err_map[31:0]; // RL18
			`KRS_OFF_ERRHI:  rmux = err_map[63:32]; // RL18
			`KRS_OFF_SUPLO:  rmux = supp_en_q[31:0];
			`KRS_OFF_SUPHI:  rmux = supp_en_q[63:32];
			default:         rmux = 32'h0;
		endcase
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_q <= 32'h0;
		else if (acc && !hwrite)
			rdata_q <= rmux;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [5:0] uk_q;
	always_ff @(posedge hclk) uk_q <= uk;
	sequence s_last_burst;
		cal_end && !cal_cmd;
	endsequence
	AST_CAL_LEN: assert property (s_last_burst |=> !cal_busy_q) // RL14
		else $error("full cal did not end after 26 bursts");
	AST_CAL_CNT: assert property (cal_busy_q |-> cal_cnt_q < `KRS_FULL_CAL_BURSTS) // RL14
		else $error("cal counter overran");
	AST_CAL_START: assert property (cal_cmd |=> cal_busy_q && cal_cnt_q == 5'h00) // RL13 RL15
		else $error("recalibrate did not start");
	AST_NO_AUTOCAL: assert property (!cal_busy_q && !cal_cmd |=> !cal_busy_q) // RL9
		else $error("recalibration started by itself");
	AST_BOUND_HI: assert property (upd_ok && upd.reference > 8'd191 |=> err_hi_q[uk_q]) // RL16
		else $error("high boundary error missing");
	AST_BOUND_LO: assert property (upd_ok && upd.reference < 8'd64 |=> err_lo_q[uk_q]) // RL16
		else $error("low boundary error missing");
	AST_GUARD_ARM: assert property (upd_ok && !armed_q[uk] && !b_hi && !b_lo
		|=> !err_hi_q[uk_q] && !err_lo_q[uk_q]) // RL6
		else $error("guard error on unarmed key");
	AST_FAST: assert property (fast_req && fast_key < NUM_KEYS
		|=> fast_set.valid && fast_set.key == $past(fast_key)) // RL14 RL23
		else $error("fast recal not done in one cycle");
	AST_SUPP: assert property (##1 (det_q & $past(beaten)) == 64'h0) // RL11
		else $error("suppressed key reported");
	AST_SETUP: assert property (setup_chk_q |=> backup_copy != backup_restore) // RL22
		else $error("setup store check missing");
endmodule // krs_supervisor

// ---- tb/krs_host_model.sv ----
`timescale 1ns/1ps
`include "krs_defs.svh"
module krs_host_model (
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel = 1'b0,
	output logic [31:0]      haddr = 32'h0,
	output logic [1:0]       htrans = 2'h0,
	output logic             hwrite = 1'b0,
	output logic [2:0]       hsize = 3'h2,
	output logic [31:0]      hwdata = 32'h0
);
	int hangs = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Bounded wait; a stuck slave is counted, not waited on forever
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n >= 50)
			hangs++;
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		xfer(1'b0, a, 32'h0, q);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic load_coef();
		wr(`KRS_OFF_COEF, 32'h0008_05e9);
	endtask
	// Host recovers keys itself; the device never does
	task automatic recal(input logic [31:0] scope);
		wr(`KRS_OFF_SCOPE, scope);
		wr(`KRS_OFF_CTRL, 32'h2);
	endtask
endmodule // krs_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "krs_defs.svh"
module tb_top;
	import krs_pkg::*;
	localparam int NK = 8;
	logic             hclk = 1'b0;
	logic             hresetn = 1'b0;
	logic             hsel, hwrite, hreadyout, hresp;
	logic [31:0]      haddr, hwdata, hrdata, q;
	logic [1:0]       htrans;
	logic [2:0]       hsize;
	krs_update_type   upd = '0;
	logic             burst_tick = 1'b0;
	logic             fast_req = 1'b0;
	logic [5:0]       fast_key = 6'h0;
	krs_fast_set_type fast_set;
	logic [NK-1:0]    cal_keys, detect_keys;
	logic             store_valid = 1'b1;
	logic             store_mismatch = 1'b0;
	logic             backup_copy, backup_restore;
	logic             seen_cp = 1'b0;
	logic             seen_rs = 1'b0;
	int               miscompares = 0;
	int               checks_done = 0;
	int               k, r;
	int               corner[4] = '{63, 64, 191, 192};
	always #5 hclk = ~hclk;
	krs_host_model host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	krs_supervisor #(.NUM_KEYS(NK)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.upd(upd), .burst_tick(burst_tick), .fast_req(fast_req), .fast_key(fast_key),
		.fast_set(fast_set), .cal_keys(cal_keys), .detect_keys(detect_keys),
		.store_valid(store_valid), .store_mismatch(store_mismatch),
		.backup_copy(backup_copy), .backup_restore(backup_restore));
	// Pulses are one cycle wide, so latch them for later comparison
	always @(posedge hclk) begin
		if (backup_copy === 1'b1)
			seen_cp <= 1'b1;
		if (backup_restore === 1'b1)
			seen_rs <= 1'b1;
	end
	// A stuck bus ends the run at once
	always @(posedge hclk) begin
		if (host.hangs != 0) begin
			miscompares++;
			print_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic up(int kk, int rr, int s, int c, int o, logic d);
		@(posedge hclk);
		upd <= '{1'b1, 6'(kk), 8'(rr), 8'(s), 4'(c), 8'(o), d};
		@(posedge hclk);
		upd.valid <= 1'b0;
	endtask
	task automatic ticks(int n);
		repeat (n) begin
			@(posedge hclk);
			burst_tick <= 1'b1;
			@(posedge hclk);
			burst_tick <= 1'b0;
		end
		@(negedge hclk);
	endtask
	task automatic kerr(int kk, output logic [31:0] v);
		host.wr(`KRS_OFF_KEYSEL, 32'(kk));
		host.rd(`KRS_OFF_KEYERR, v);
	endtask
	function automatic logic [31:0] bnd(int rr);
		return {30'h0, rr < 64, rr > 191};
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#900000;
		miscompares++;
		print_verdict();
	end
	initial begin
		void'($urandom(32'h4924));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		@(negedge hclk);
		chk("copy", {seen_cp, seen_rs}, 32'h2);
		chk("cal_rst", 32'(cal_keys), 32'hff);
		chk("bus", {hreadyout, hresp}, 32'h2);
		host.rd(`KRS_OFF_STATUS, q);
		chk("st_cal", 32'(q[1]), 32'h1);
		$display("test reset done");
		// Corners first, then random keys and levels
		for (int i = 0; i < 12; i++) begin
			k = $urandom_range(NK - 1);
			r = (i < 4) ? corner[i] : $urandom_range(255);
			up(k, r, r, 0, 0, 1'b0);
			kerr(k, q);
			chk("keyerr", 32'(q[3:2]), bnd(r));
			host.rd(`KRS_OFF_ERRLO, q);
			chk("errfield", 32'(q[k]), 32'(bnd(r) != 0));
		end
		$display("test boundary done");
		ticks(25);
		chk("cal_25", 32'(cal_keys), 32'hff);
		ticks(1);
		chk("cal_26", 32'(cal_keys), 32'h0);
		host.wr(`KRS_OFF_GUARD, 32'h000a);
		host.wr(`KRS_OFF_GUARD, 32'h0064);
		host.wr(`KRS_OFF_GUARD, 32'h650a);
		host.rd(`KRS_OFF_GUARD, q);
		chk("guard_rej", q, 32'h000a);
		host.wr(`KRS_OFF_GUARD, 32'h6463);
		host.rd(`KRS_OFF_GUARD, q);
		chk("guard_max", q, 32'h6463);
		host.wr(`KRS_OFF_GUARD, 32'h000a);
		host.rd(8'h40, q);
		chk("unmapped", q, 32'h0);
		$display("test calib done");
		host.load_coef();
		up(0, 128, 128, 1, 2, 1'b0);
		up(1, 128, 128, 0, 0, 1'b0);
		host.wr(`KRS_OFF_CTRL, 32'h1);
		repeat (12) @(posedge hclk);
		up(0, 128, 128, 0, 2, 1'b0);
		kerr(0, q);
		chk("guard_idle", 32'(q[3:2]), 32'h0);
		host.recal(32'h100);
		@(posedge hclk);
		@(negedge hclk);
		chk("recal", 32'(cal_keys), 32'hff);
		ticks(26);
		up(0, 128, 128, 0, 2, 1'b0);
		kerr(0, q);
		chk("guard_low", 32'(q[3:2]), 32'h2);
		up(1, 128, 128, 1, 0, 1'b0);
		kerr(1, q);
		chk("guard_off", 32'(q[3:2]), 32'h0);
		host.wr(`KRS_OFF_GUARD, 32'h010a);
		up(1, 128, 128, 1, 0, 1'b0);
		kerr(1, q);
		chk("guard_high", 32'(q[3:2]), 32'h1);
		host.rd(`KRS_OFF_ERRLO, q);
		chk("guard_field", 32'(q[1:0]), 32'h3);
		chk("no_autocal", 32'(cal_keys), 32'h0);
		$display("test guard done");
		host.wr(`KRS_OFF_SUPLO, 32'h30);
		up(4, 128, 100, 0, 0, 1'b1);
		up(5, 128, 110, 0, 0, 1'b1);
		up(6, 128, 80, 0, 0, 1'b1);
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk("suppress", 32'(detect_keys[6:4]), 32'h5);
		host.rd(`KRS_OFF_STATUS, q);
		chk("st_det", 32'(q[2:0]), 32'h5);
		@(posedge hclk);
		fast_req <= 1'b1;
		fast_key <= 6'h4;
		@(posedge hclk);
		fast_req <= 1'b0;
		@(negedge hclk);
		chk("fast", 32'(fast_set), {17'h0, 1'b1, 6'h4, 8'd100});
		$display("test suppress done");
		host.rd(`KRS_OFF_STATUS, q);
		chk("st_setup", 32'(q[4]), 32'h1);
		host.recal(32'h3);
		host.recal(32'h5);
		@(negedge hclk);
		chk("scope_or", 32'(cal_keys), 32'h28);
		@(posedge hclk);
		store_valid <= 1'b0;
		host.wr(`KRS_OFF_CTRL, 32'h4);
		repeat (8) @(posedge hclk);
		@(negedge hclk);
		chk("restore", 32'(seen_rs), 32'h1);
		chk("soft_cal", 32'(cal_keys), 32'hff);
		host.rd(`KRS_OFF_STATUS, q);
		chk("st_clean", 32'(q[4]), 32'h0);
		store_mismatch <= 1'b1;
		host.rd(`KRS_OFF_STATUS, q);
		chk("st_mismatch", 32'(q[4]), 32'h1);
		chk("hangs", 32'(host.hangs), 32'h0);
		$display("test setup done");
		print_verdict();
	end
endmodule // tb_top
